// ---- rtl/sdtx_pkg.sv ----
// Constants and types for the four-channel transmit input and status block.
// Assumes one APB slave per device; all channels share the register words.
package sdtx_pkg;

  localparam int CH_COUNT = 4;
  localparam int APB_AW   = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_CFG    = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MASK   = 12'h008;
  localparam logic [11:0] OFS_CMD    = 12'h00C;
  localparam logic [11:0] OFS_STATE  = 12'h010;

  // Per-channel configuration byte, channel n at bits [8n+7:8n]
  localparam int CFG_LANE      = 8;
  localparam int F_IFSEL       = 0;
  localparam int F_RECENTER    = 1;
  localparam int F_SELFTEST_N  = 2;
  localparam int F_RXSEL       = 3;
  localparam int F_OE1         = 4;
  localparam int F_OE2         = 5;
  localparam int F_BYPASS      = 6;
  localparam int F_HALFRATE    = 7;
  localparam logic [31:0] CFG_RST = 32'h3636_3636;

  // Status and mask layout: error events low, self-test passes high
  localparam int ST_PASS_BASE = 4;

  // Phase-align buffer
  localparam int PAB_DEPTH_DEF = 8;

  // Self-test pass period in character times
  localparam logic [9:0] BIST_LEN_RX1 = 10'h20F;
  localparam logic [9:0] BIST_LEN_RX0 = 10'h1FF;

  // Control code meanings with the encoder on
  localparam logic [1:0] CTRL_DATA    = 2'h0;
  localparam logic [1:0] CTRL_SPECIAL = 2'h1;

  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_SPECIAL,
    KIND_REPLACE,
    KIND_RAW
  } sdtx_kind_e;

endpackage : sdtx_pkg

// ---- rtl/sdtx_tx_input.sv ----
// Four-channel transmit parallel input, phase-align buffer and error status.
// Assumes pclk is far faster than the interface clocks; all pins are async.
//
// Behaviour
// - Each chosen interface clock rising edge captures the 8-bit character.
// - The same edge captures the 2-bit control code with the character.
// - A per-channel select picks input clock or reference clock for capture.
// - With encoding on, the captured character is the one to send.
// - With encoding bypassed, the control bits become extra data bits.
// - With encoding on, the control bits pick data, special or replacement.
// - Buffer underflow or overflow drives the channel error output high.
// - That error holds until a word sync is sent or the buffer is recentred.
// - With self-test enable low, the error output shows self-test progress.
// - Each self-test pass gives a pulse of exactly one character period.
// - The pass period is 527 characters with rx select 1, else 511.
// - Error output is high while both serial output enables are 0.
// - With select 0, the channel's input clock paces the inputs.
// - Writing the recentre latch as 0 initialises the buffer phase.
// - In half-rate mode the inputs are taken on both reference edges.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module sdtx_tx_input #(
  parameter int PAB_DEPTH = sdtx_pkg::PAB_DEPTH_DEF
) (
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [sdtx_pkg::APB_AW-1:0]               paddr,
  input  wire logic [31:0]                               pwdata,
  output logic                                           pready,
  output logic [31:0]                                    prdata,
  output logic                                           pslverr,
  output logic                                           irq,
  input  wire logic [sdtx_pkg::CH_COUNT-1:0]             tx_input_clock,
  input  wire logic [sdtx_pkg::CH_COUNT-1:0]             channel_reference_clock,
  input  wire logic [sdtx_pkg::CH_COUNT-1:0][7:0]        tx_char_in,
  input  wire logic [sdtx_pkg::CH_COUNT-1:0][1:0]        tx_ctrl_code_in,
  output logic [sdtx_pkg::CH_COUNT-1:0]                  tx_path_error,
  output logic [sdtx_pkg::CH_COUNT-1:0][9:0]             tx_word,
  output sdtx_pkg::sdtx_kind_e [sdtx_pkg::CH_COUNT-1:0]  tx_word_kind,
  output logic [sdtx_pkg::CH_COUNT-1:0]                  tx_word_valid
);
  import sdtx_pkg::*;

  localparam int PW = $clog2(PAB_DEPTH);
  localparam logic [PW:0]   OCC_FULL = (PW+1)'(PAB_DEPTH);
  localparam logic [PW:0]   OCC_MID  = (PW+1)'(PAB_DEPTH / 2);
  localparam logic [PW-1:0] WP_MID   = PW'(PAB_DEPTH / 2);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0]         cfg_reg;
  logic [7:0]          status_reg;
  logic [7:0]          mask_reg;
  logic [CH_COUNT-1:0] recenter_reg;
  logic [CH_COUNT-1:0] sync_reg;
  logic [CH_COUNT-1:0] err_ev;
  logic [CH_COUNT-1:0] pass_ev;
  logic [CH_COUNT-1:0] err_lat_vis;
  logic [7:0]          ev_vec;
  logic                acc_wr;
  logic                rd_setup;
  logic                hit;
  logic [31:0]         rd_next;

  assign acc_wr   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = (paddr == OFS_CFG) || (paddr == OFS_STATUS) || (paddr == OFS_MASK)
                 || (paddr == OFS_CMD) || (paddr == OFS_STATE);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign ev_vec   = {pass_ev, err_ev};
  assign irq      = |(status_reg & mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= CFG_RST;
      mask_reg <= 8'h00;
    end else if (acc_wr && paddr == OFS_CFG) begin
      cfg_reg <= pwdata;
    end else if (acc_wr && paddr == OFS_MASK) begin
      mask_reg <= pwdata[7:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
    end else if (acc_wr && paddr == OFS_STATUS) begin
      status_reg <= (status_reg & ~pwdata[7:0]) | ev_vec;
    end else begin
      status_reg <= status_reg | ev_vec;
    end
  end

  // One-cycle strobes: recentre on a write of 0, word sync by command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recenter_reg <= '0;
      sync_reg     <= '0;
    end else begin
      for (int c = 0; c < CH_COUNT; c++) begin
        recenter_reg[c] <= acc_wr && paddr == OFS_CFG
                           && !pwdata[c*CFG_LANE+F_RECENTER];
        sync_reg[c]     <= acc_wr && paddr == OFS_CMD && pwdata[c];
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (paddr == OFS_CFG) begin
      rd_next = cfg_reg;
    end else if (paddr == OFS_STATUS) begin
      rd_next = {24'h00_0000, status_reg};
    end else if (paddr == OFS_MASK) begin
      rd_next = {24'h00_0000, mask_reg};
    end else if (paddr == OFS_STATE) begin
      rd_next = {24'h00_0000, err_lat_vis, tx_path_error};
    end
  end

  // Read data latched in the setup cycle so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_next;
    end
  end

  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_ch
    logic [2:0]     tck_s;
    logic [2:0]     rck_s;
    logic [9:0]     din_s1;
    logic [9:0]     din_s2;
    logic [9:0]     pab_mem [PAB_DEPTH];
    logic [PW-1:0]  wp_reg;
    logic [PW-1:0]  rp_reg;
    logic [PW:0]    occ_reg;
    logic [9:0]     word_reg;
    sdtx_kind_e     kind_reg;
    logic           valid_reg;
    logic           err_lat_reg;
    logic [9:0]     bist_cnt_reg;
    logic           bist_pulse_reg;
    logic           err_out_reg;
    logic           ifsel;
    logic           bypass;
    logic           half;
    logic           bist_on;
    logic           pll_down;
    logic [9:0]     bist_len;
    logic           tx_rise;
    logic           ref_rise;
    logic           ref_fall;
    logic           stb;
    logic           cap;
    logic           ovf;
    logic           udf;
    logic           wr_ok;
    logic           rd_ok;
    logic           src_ok;
    logic [9:0]     src;
    logic           wrap;
    sdtx_kind_e     kind_next;

    assign ifsel    = cfg_reg[ch*CFG_LANE+F_IFSEL];
    assign bypass   = cfg_reg[ch*CFG_LANE+F_BYPASS];
    assign half     = cfg_reg[ch*CFG_LANE+F_HALFRATE];
    assign bist_on  = !cfg_reg[ch*CFG_LANE+F_SELFTEST_N];
    assign pll_down = !cfg_reg[ch*CFG_LANE+F_OE1] && !cfg_reg[ch*CFG_LANE+F_OE2];
    assign bist_len = cfg_reg[ch*CFG_LANE+F_RXSEL] ? BIST_LEN_RX1 : BIST_LEN_RX0;

    // Two-stage synchronisers; a third clock stage holds edge history only
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tck_s  <= 3'h0;
        rck_s  <= 3'h0;
        din_s1 <= 10'h000;
        din_s2 <= 10'h000;
      end else begin
        tck_s  <= {tck_s[1:0], tx_input_clock[ch]};
        rck_s  <= {rck_s[1:0], channel_reference_clock[ch]};
        din_s1 <= {tx_ctrl_code_in[ch], tx_char_in[ch]};
        din_s2 <= din_s1;
      end
    end

    assign tx_rise  = tck_s[1] & ~tck_s[2];
    assign ref_rise = rck_s[1] & ~rck_s[2];
    assign ref_fall = ~rck_s[1] & rck_s[2];
    assign stb      = ref_rise | (half & ref_fall);
    assign cap      = ifsel ? stb : tx_rise;

    // Buffer only in use when the input clock paces capture
    assign ovf    = cap && !ifsel && occ_reg == OCC_FULL && !stb;
    assign udf    = stb && !ifsel && occ_reg == '0;
    assign wr_ok  = cap && !ifsel && !ovf;
    assign rd_ok  = stb && !ifsel && occ_reg != '0;
    assign err_ev[ch] = ovf | udf;

    always_ff @(posedge pclk) begin
      if (wr_ok) begin
        pab_mem[wp_reg] <= din_s2;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wp_reg  <= WP_MID;
        rp_reg  <= '0;
        occ_reg <= OCC_MID;
      end else if (recenter_reg[ch]) begin
        wp_reg  <= WP_MID;
        rp_reg  <= '0;
        occ_reg <= OCC_MID;
      end else begin
        if (wr_ok) begin
          wp_reg <= wp_reg + 1'b1;
        end
        if (rd_ok) begin
          rp_reg <= rp_reg + 1'b1;
        end
        occ_reg <= occ_reg + (PW+1)'(wr_ok) - (PW+1)'(rd_ok);
      end
    end

    assign src    = ifsel ? din_s2 : pab_mem[rp_reg];
    assign src_ok = ifsel ? stb : rd_ok;

    always_comb begin
      if (bypass) begin
        kind_next = KIND_RAW;
      end else if (src[9:8] == CTRL_DATA) begin
        kind_next = KIND_DATA;
      end else if (src[9:8] == CTRL_SPECIAL) begin
        kind_next = KIND_SPECIAL;
      end else begin
        kind_next = KIND_REPLACE;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_reg  <= 10'h000;
        kind_reg  <= KIND_DATA;
        valid_reg <= 1'b0;
      end else begin
        valid_reg <= src_ok;
        if (src_ok) begin
          word_reg <= src;
          kind_reg <= kind_next;
        end
      end
    end

    // Event beats the clear arriving in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        err_lat_reg <= 1'b0;
      end else begin
        err_lat_reg <= err_ev[ch]
                    | (err_lat_reg & ~(sync_reg[ch] | recenter_reg[ch]));
      end
    end

    assign wrap        = bist_on && stb && bist_cnt_reg >= bist_len - 10'h001;
    assign pass_ev[ch] = wrap;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bist_cnt_reg   <= 10'h000;
        bist_pulse_reg <= 1'b0;
      end else if (!bist_on) begin
        bist_cnt_reg   <= 10'h000;
        bist_pulse_reg <= 1'b0;
      end else if (stb) begin
        bist_cnt_reg   <= wrap ? 10'h000 : bist_cnt_reg + 10'h001;
        bist_pulse_reg <= wrap;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        err_out_reg <= 1'b0;
      end else begin
        err_out_reg <= pll_down | (bist_on ? bist_pulse_reg : err_lat_reg);
      end
    end

    assign tx_path_error[ch] = err_out_reg;
    assign tx_word[ch]       = word_reg;
    assign tx_word_kind[ch]  = kind_reg;
    assign tx_word_valid[ch] = valid_reg;
    assign err_lat_vis[ch]   = err_lat_reg;

    sequence s_wrap;
      wrap ##1 bist_pulse_reg;
    endsequence

    property p_cap_char;
      (stb && ifsel) |=> word_reg[7:0] == $past(din_s2[7:0]) && valid_reg;
    endproperty
    a_cap_char: assert property (p_cap_char) else $error("char not captured");

    property p_cap_ctrl;
      (stb && ifsel) |=> word_reg[9:8] == $past(din_s2[9:8]);
    endproperty
    a_cap_ctrl: assert property (p_cap_ctrl) else $error("ctrl not captured");

    property p_clk_sel;
      (ifsel && !stb) |=> !valid_reg;
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("wrong capture clock");

    property p_raw;
      (src_ok && bypass) |=> kind_reg == KIND_RAW;
    endproperty
    a_raw: assert property (p_raw) else $error("bypass not raw");

    property p_kind;
      (src_ok && !bypass && src[9:8] == CTRL_SPECIAL) |=> kind_reg == KIND_SPECIAL;
    endproperty
    a_kind: assert property (p_kind) else $error("control code misread");

    property p_err_set;
      (err_ev[ch] && !bist_on) |-> ##2 tx_path_error[ch];
    endproperty
    a_err_set: assert property (p_err_set) else $error("error not flagged");

    property p_err_hold;
      (err_lat_reg && !sync_reg[ch] && !recenter_reg[ch]) |=> err_lat_reg;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped early");

    property p_bist_out;
      (bist_on && $past(bist_on) && !$past(pll_down)) |-> err_out_reg == $past(bist_pulse_reg);
    endproperty
    a_bist_out: assert property (p_bist_out) else $error("self-test not shown");

    property p_pulse_one;
      (bist_on && stb && bist_pulse_reg) |=> !bist_pulse_reg;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pass pulse length");

    property p_pulse_rise;
      wrap |-> s_wrap;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise) else $error("pass pulse missing");

    property p_pll;
      pll_down |=> tx_path_error[ch];
    endproperty
    a_pll: assert property (p_pll) else $error("pll down not flagged");

    property p_recenter;
      (recenter_reg[ch] && !err_ev[ch]) |=> occ_reg == OCC_MID && !err_lat_reg;
    endproperty
    a_recenter: assert property (p_recenter) else $error("recentre failed");
  end

endmodule : sdtx_tx_input

// ---- testbench/sdtx_host_model.sv ----
// Host logic model: drives characters and interface clocks on all channels.
// Assumes the bench sets run, skew and ctrl from the pclk domain.
`timescale 1ns/1ps
module sdtx_host_model (
  input  wire logic       run,
  input  wire logic       skew,
  input  wire logic [1:0] ctrl,
  output logic [3:0]      tx_input_clock,
  output logic [3:0]      channel_reference_clock,
  output logic [3:0][7:0] tx_char_in,
  output logic [3:0][1:0] tx_ctrl_code_in,
  output logic [9:0]      word_at_edge
);
  logic       fast_clk;
  logic [7:0] seq;

  // Ch0 drifts fast only when a scenario asks for a buffer fault
  initial begin
    fast_clk = 1'b0;
    forever begin
      #150;
      fast_clk = run & skew & ~fast_clk;
    end
  end

  always_comb begin
    tx_input_clock    = channel_reference_clock;
    tx_input_clock[0] = skew ? fast_clk : channel_reference_clock[0];
  end

  initial begin
    seq = 8'h5A;
    channel_reference_clock = '0;
    tx_char_in = '0;
    tx_ctrl_code_in = '0;
    word_at_edge = '0;
    forever begin
      if (!run) begin
        // Clocks stand still; released data toggles so nothing stale looks valid
        tx_char_in = ~tx_char_in;
        #200;
      end else begin
        channel_reference_clock = '1;
        word_at_edge = {tx_ctrl_code_in[0], tx_char_in[0]};
        #200;
        channel_reference_clock = '0;
        seq = seq + 8'h3B;
        tx_char_in = {4{seq}};
        tx_ctrl_code_in = {4{ctrl}};
        #200;
      end
    end
  end
endmodule : sdtx_host_model

// ---- testbench/sdtx_tx_input_tb.sv ----
// Bench for the transmit input block: APB tasks, host model traffic, checks.
// Assumes the host model makes every interface clock; pclk is 20 MHz.
`timescale 1ns/1ps
module sdtx_tx_input_tb;
  import sdtx_pkg::*;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic                      run, skew, check_en, bypass, er;
  logic [APB_AW-1:0]         paddr;
  logic [31:0]               pwdata, prdata, r;
  logic [1:0]                ctrl;
  logic [CH_COUNT-1:0]       tck, rck, perr, wvalid;
  logic [CH_COUNT-1:0][7:0]  chr;
  logic [CH_COUNT-1:0][1:0]  cc;
  logic [CH_COUNT-1:0][9:0]  word;
  logic [9:0]                host_word;
  sdtx_kind_e [CH_COUNT-1:0] wkind;
  int                        fails, comparisons, n, w;

  sdtx_tx_input #(.PAB_DEPTH(PAB_DEPTH_DEF)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .tx_input_clock(tck), .channel_reference_clock(rck), .tx_char_in(chr),
    .tx_ctrl_code_in(cc), .tx_path_error(perr), .tx_word(word), .tx_word_kind(wkind),
    .tx_word_valid(wvalid));
  sdtx_host_model host (
    .run(run), .skew(skew), .ctrl(ctrl), .tx_input_clock(tck),
    .channel_reference_clock(rck), .tx_char_in(chr), .tx_ctrl_code_in(cc),
    .word_at_edge(host_word));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic give_up();
    fails++;
    finish_test();
  endtask : give_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) give_up();
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_err(input int ch, input logic v, input int lim);
    int t;
    t = 0;
    while (perr[ch] !== v && t < lim) begin
      @(posedge pclk);
      t++;
    end
    chk("tx_path_error", {31'h0, v}, {31'h0, perr[ch]});
  endtask : wait_err

  // Counts words over whole reference periods so sync delay cancels out
  task automatic count_valids(input int ch, input int edges, output int cnt);
    int   e;
    int   t;
    logic prev;
    cnt = 0;
    e = 0;
    t = 0;
    prev = rck[ch];
    while (e <= edges && t < 20000) begin
      @(posedge pclk);
      t++;
      if (rck[ch] && !prev) e++;
      prev = rck[ch];
      if (e >= 1 && e <= edges && wvalid[ch] === 1'b1) cnt++;
    end
    if (t >= 20000) give_up();
  endtask : count_valids

  task automatic bist_period(input int ch, output int cnt, output int wid);
    int   ph;
    int   t;
    logic prev;
    cnt = 0;
    wid = 0;
    ph = 0;
    t = 0;
    prev = perr[ch];
    while (ph < 2 && t < 20000) begin
      @(posedge pclk);
      t++;
      if (perr[ch] === 1'b1 && prev === 1'b0) ph++;
      prev = perr[ch];
      if (ph == 1 && wvalid[ch] === 1'b1) cnt++;
      if (ph == 1 && perr[ch] === 1'b1) wid++;
    end
    if (t >= 20000) give_up();
  endtask : bist_period

  function automatic logic [31:0] exp_kind(input logic [1:0] c);
    if (bypass) return {30'h0, KIND_RAW};
    if (c == 2'b00) return {30'h0, KIND_DATA};
    return (c == 2'b01) ? {30'h0, KIND_SPECIAL} : {30'h0, KIND_REPLACE};
  endfunction : exp_kind

  always @(posedge pclk) begin
    for (int c = 0; c < CH_COUNT; c++) begin
      if (check_en && wvalid[c] === 1'b1) begin
        chk("tx_word", {22'h0, host_word}, {22'h0, word[c]});
        chk("tx_word_kind", exp_kind(host_word[9:8]), {30'h0, wkind[c]});
      end
    end
  end

  initial begin
    {psel, penable, pwrite, run, skew, check_en, bypass} = '0;
    paddr = '0;
    pwdata = '0;
    ctrl = '0;
    fails = 0;
    comparisons = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", 32'h3636_3636, r);
    apb(1'b0, OFS_MASK, 32'h0);
    chk("mask", 32'h0000_0000, r);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {31'h0, 1'b1}, {31'h0, er});
    chk("tx_path_error", 32'h0, {28'h0, perr});
    apb(1'b1, OFS_CFG, 32'h3737_3737);
    run <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        check_en <= 1'b0;
        apb(1'b1, OFS_CFG, (b == 1) ? 32'h7777_7777 : 32'h3737_3737);
        bypass <= b[0];
        ctrl   <= c[1:0];
        count_valids(3, 2, n);
        check_en <= 1'b1;
        count_valids(3, 12, n);
        chk("chars", 32'd12, n);
      end
    end
    check_en <= 1'b0;
    apb(1'b1, OFS_CFG, 32'hB7B7_B7B7);
    count_valids(2, 2, n);
    count_valids(2, 10, n);
    chk("half rate chars", 32'd20, n);
    apb(1'b1, OFS_CFG, 32'h3737_3337);
    bist_period(1, n, w);
    chk("pass period", 32'd511, n);
    chk("pulse width", 32'd8, w);
    apb(1'b1, OFS_CFG, 32'h3737_3B37);
    bist_period(1, n, w);
    chk("pass period", 32'd527, n);
    apb(1'b1, OFS_CFG, 32'h3707_3B37);
    wait_err(2, 1'b1, 10);
    chk("other channel", 32'h0, {31'h0, perr[3]});
    apb(1'b1, OFS_CFG, 32'h3636_3634);
    apb(1'b1, OFS_CFG, 32'h3636_3636);
    skew <= 1'b1;
    wait_err(0, 1'b1, 2000);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h0000_0021, r);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("state", 32'h0000_0011, r);
    run  <= 1'b0;
    skew <= 1'b0;
    repeat (100) @(posedge pclk);
    chk("held error", 32'h1, {31'h0, perr[0]});
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    wait_err(0, 1'b0, 10);
    apb(1'b1, OFS_STATUS, 32'h0000_00FF);
    chk("irq cleared", 32'h0, {31'h0, irq});
    run  <= 1'b1;
    skew <= 1'b1;
    wait_err(0, 1'b1, 2000);
    run  <= 1'b0;
    skew <= 1'b0;
    apb(1'b1, OFS_CFG, 32'h3636_3634);
    wait_err(0, 1'b0, 10);
    finish_test();
  end
endmodule : sdtx_tx_input_tb
